/* File: core/acst_pkg.sv */
// Purpose: shared constants and types of the conversion timing block
// Assumes: CLK_SYS runs at twice the instruction rate (half-cycle steps)
// Notes: every count here is in conversion clock periods unless named
package acst_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int DIV_W = 6;
    localparam int SAMC_W = 5;
    localparam int RES_W = 10;
    localparam int SH_W = 2;
    localparam int FIFO_DEPTH = 8;
    localparam logic [4:0] CONV_TADS = 5'h0C;
    localparam logic [4:0] CONV_LAST = 5'h0B;
    localparam logic [4:0] MIN_SAMPLE_TADS = 5'h01;
    localparam logic [4:0] CNT_MAX = 5'h1F;
    localparam logic [2:0] TRIG_SW = 3'h0;
    localparam logic [2:0] TRIG_AUTO = 3'h7;
    localparam logic [1:0] CHPS_ONE = 2'h0;
    localparam logic [1:0] CHPS_TWO = 2'h1;
    localparam logic [3:0] SH_MASK_ONE = 4'h1;
    localparam logic [3:0] SH_MASK_TWO = 4'h3;
    localparam logic [3:0] SH_MASK_FOUR = 4'hF;
    localparam logic [DIV_W-1:0] DIV_RESET = 6'h00;
    localparam logic [SH_W-1:0] SH_RESET = 2'h0;

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONV, ST_HOLD}
        acst_state_t;
endpackage

/* File: core/acst_stream_if.sv */
// Purpose: valid/ready word stream between the sequencer and the fifo
// Assumes: one clock for both ends
// Notes: a word moves on a cycle where valid and ready are both high
`timescale 1ns/1ps
interface acst_stream_if #(parameter int W = 12);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* File: core/acst_fifo.sv */
// Purpose: result fifo with registered read data
// Assumes: writer holds data while valid is high and ready is low
// Notes: depth counts the memory only; the output register adds one word
`timescale 1ns/1ps
module acst_fifo
    import acst_pkg::*;
#(
    parameter int W = 12,
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    acst_stream_if.snk wr,
    acst_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [CW-1:0] cnt_q;
    logic ov_q;
    logic [W-1:0] od_q;
    logic do_wr;
    logic do_ld;

    // full is honest: ready drops exactly when the memory holds depth words
    assign wr.ready = (cnt_q != FULL_CNT);
    assign do_wr = ce && wr.valid && wr.ready;
    assign do_ld = ce && (cnt_q != '0) && (!ov_q || rd.ready);
    assign rd.valid = ov_q;
    assign rd.data = od_q;

    // storage has no reset; only the pointers define what is valid
    always_ff @(posedge clk)
    begin
        if (do_wr)
            mem_q[wp_q] <= wr.data;
    end

    // pointers and occupancy
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else if (ce)
        begin
            if (do_wr)
                wp_q <= (wp_q == LAST_PTR) ? '0 : wp_q + 1'b1;
            if (do_ld)
                rp_q <= (rp_q == LAST_PTR) ? '0 : rp_q + 1'b1;
            if (do_wr && !do_ld)
                cnt_q <= cnt_q + 1'b1;
            else if (!do_wr && do_ld)
                cnt_q <= cnt_q - 1'b1;
        end
    end

    // output register refills the cycle it is taken, so no bubble
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ov_q <= 1'b0;
            od_q <= '0;
        end
        else if (ce)
        begin
            if (do_ld)
            begin
                ov_q <= 1'b1;
                od_q <= mem_q[rp_q];
            end
            else if (rd.ready)
                ov_q <= 1'b0;
        end
    end

    property p_no_overflow;
        @(posedge clk) disable iff (rst)
        (cnt_q == FULL_CNT) |-> !wr.ready ##1 (cnt_q <= FULL_CNT);
    endproperty
    a_no_overflow: assert property (p_no_overflow)
        else $error("fifo accepted a word while full");

    property p_out_held;
        @(posedge clk) disable iff (rst)
        ce && rd.valid && !rd.ready |=> rd.valid && $stable(rd.data);
    endproperty
    a_out_held: assert property (p_out_held)
        else $error("fifo output changed while stalled");
endmodule

/* File: core/acst_top.sv */
// Purpose: conversion clock generator and sample/convert sequencer
// Assumes: CLK_SYS is twice the instruction rate; SAR_RESULT is stable
//          from the analog side when the last conversion period ends
// Notes: results with their sample-and-hold index go out through a fifo
`timescale 1ns/1ps
module acst_top
    import acst_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    input wire logic MODULE_ON,
    input wire logic RC_CLOCK_SELECT,
    input wire logic RC_OSC_PIN,
    input wire logic [DIV_W-1:0] CONV_CLOCK_DIVIDER,
    input wire logic [2:0] TRIGGER_SOURCE,
    input wire logic AUTO_SAMPLE_ENABLE,
    input wire logic SAMPLE_HOLD_BIT,
    input wire logic SIMULTANEOUS_SAMPLE,
    input wire logic [1:0] SH_CHANNEL_COUNT,
    input wire logic [SAMC_W-1:0] AUTO_SAMPLE_CLOCKS,
    input wire logic [3:0] INPUT_SELECT,
    input wire logic EXT_TRIGGER,
    input wire logic [RES_W-1:0] SAR_RESULT,
    input wire logic RESULT_READY,
    output logic SAMPLING,
    output logic CONVERTING,
    output logic [3:0] SH_ACQUIRE,
    output logic [SH_W-1:0] SH_CONVERT,
    output logic RESULT_VALID,
    output logic [SH_W+RES_W-1:0] RESULT_DATA
);
    localparam int DW = SH_W + RES_W;

    acst_state_t st_q, st_d, nxt_st;
    logic rc_s1_q, rc_s2_q, rc_s3_q;
    logic [DIV_W-1:0] div_q;
    logic [4:0] cnt_q;
    logic [SH_W-1:0] sh_q, nsh;
    logic [RES_W-1:0] res_q;
    logic [3:0] chan_q;
    logic sample_hold_bit_bit_q, trg_q;
    logic rc_edge, div_tick, tad_tick;
    logic [4:0] sample_hold_bit_need;
    logic trig_ev, end_sample_hold_bit, conv_done, last_sh, push_ok, enter_conv;
    logic sample_hold_bit_met, div_hold;
    logic [3:0] sh_en;

    acst_stream_if #(.W(DW)) push_if ();
    acst_stream_if #(.W(DW)) pop_if ();

    // rc oscillator comes from a pin: two stages, then an edge stage
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
            rc_s3_q <= 1'b0;
        end
        else if (CE)
        begin
            rc_s1_q <= RC_OSC_PIN;
            rc_s2_q <= rc_s1_q;
            rc_s3_q <= rc_s2_q;
        end
    end
    assign rc_edge = rc_s2_q && !rc_s3_q;

    // divider restarts in idle, hold and on a channel change, so the
    // sampling that follows always gets whole conversion clock periods
    assign div_hold = (st_q == ST_IDLE) || (st_q == ST_HOLD) ||
                      ((st_q == ST_SAMPLE) && (INPUT_SELECT != chan_q));

    // divider: each CLK_SYS cycle is half an instruction cycle
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            div_q <= DIV_RESET;
        else if (CE)
        begin
            if (!MODULE_ON || RC_CLOCK_SELECT || div_tick || div_hold)
                div_q <= DIV_RESET;
            else
                div_q <= div_q + 1'b1;
        end
    end
    // >= so a divider made smaller mid-count cannot miss its wrap
    assign div_tick = (div_q >= CONV_CLOCK_DIVIDER);
    assign tad_tick = CE && MODULE_ON &&
                      (RC_CLOCK_SELECT ? rc_edge : div_tick);

    // sample clocks: auto-convert uses the field, floored at one
    always_comb
    begin
        sample_hold_bit_need = MIN_SAMPLE_TADS;
        if (TRIGGER_SOURCE == TRIG_AUTO)
            sample_hold_bit_need = (AUTO_SAMPLE_CLOCKS == '0) ? MIN_SAMPLE_TADS
                                                   : AUTO_SAMPLE_CLOCKS;
    end

    // software trigger is the falling sample bit; others a strobe
    assign trig_ev = (TRIGGER_SOURCE == TRIG_SW) ?
                     (sample_hold_bit_bit_q && !SAMPLE_HOLD_BIT) : EXT_TRIGGER;
    // the need-th tick itself closes sampling, so no extra period is lost
    assign sample_hold_bit_met = (cnt_q >= sample_hold_bit_need) ||
                      (tad_tick && (cnt_q == sample_hold_bit_need - 5'h01));
    // a trigger arriving early waits until the least time is met;
    // a channel change in this cycle always forces a fresh interval
    assign end_sample_hold_bit = sample_hold_bit_met && (INPUT_SELECT == chan_q) &&
                      ((TRIGGER_SOURCE == TRIG_AUTO) || trg_q || trig_ev);
    assign conv_done = (st_q == ST_CONV) && tad_tick &&
                       (cnt_q == CONV_LAST);

    // channel group size: one, two or four
    always_comb
    begin
        nsh = 2'h3;
        sh_en = SH_MASK_FOUR;
        if (SH_CHANNEL_COUNT == CHPS_ONE)
        begin
            nsh = 2'h0;
            sh_en = SH_MASK_ONE;
        end
        else if (SH_CHANNEL_COUNT == CHPS_TWO)
        begin
            nsh = 2'h1;
            sh_en = SH_MASK_TWO;
        end
    end
    assign last_sh = (sh_q == nsh);
    assign push_ok = push_if.valid && push_if.ready;

    // after a result: simultaneous groups convert on without sampling
    always_comb
    begin
        nxt_st = ST_IDLE;
        if (SIMULTANEOUS_SAMPLE && !last_sh)
            nxt_st = ST_CONV;
        else if (AUTO_SAMPLE_ENABLE)
            nxt_st = ST_SAMPLE;
    end

    // sequencer next state; off overrides everything, even an auto-start
    always_comb
    begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE:
                if (AUTO_SAMPLE_ENABLE || SAMPLE_HOLD_BIT)
                    st_d = ST_SAMPLE;
            ST_SAMPLE:
                if (end_sample_hold_bit)
                    st_d = ST_CONV;
            ST_CONV:
                if (conv_done)
                    st_d = push_if.ready ? nxt_st : ST_HOLD;
            ST_HOLD:
                if (push_if.ready)
                    st_d = nxt_st;
        endcase
        if (!MODULE_ON)
            st_d = ST_IDLE;
    end
    assign enter_conv = (st_q == ST_SAMPLE) && (st_d == ST_CONV);

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            st_q <= ST_IDLE;
        else if (CE)
            st_q <= st_d;
    end

    // phase counter in conversion clocks, restarted on each phase
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            cnt_q <= '0;
        else if (CE)
        begin
            if (!MODULE_ON || st_d != st_q || conv_done)
                cnt_q <= '0;
            else if (st_q == ST_SAMPLE && INPUT_SELECT != chan_q)
                cnt_q <= '0;
            else if (tad_tick && cnt_q != CNT_MAX)
                cnt_q <= cnt_q + 1'b1;
        end
    end

    // channel index walks the group one at a time
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
            sh_q <= SH_RESET;
        else if (CE)
        begin
            if (!MODULE_ON)
                sh_q <= SH_RESET;
            else if (push_ok)
                sh_q <= last_sh ? SH_RESET : sh_q + 1'b1;
        end
    end

    // trigger memory: a new event wins over the clear on conversion start
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            trg_q <= 1'b0;
            sample_hold_bit_bit_q <= 1'b0;
            chan_q <= '0;
            res_q <= '0;
        end
        else if (CE)
        begin
            trg_q <= MODULE_ON && (trig_ev || (trg_q && !enter_conv));
            sample_hold_bit_bit_q <= SAMPLE_HOLD_BIT;
            chan_q <= INPUT_SELECT;
            if (conv_done)
                res_q <= SAR_RESULT;
        end
    end

    // result goes out on the last period; a full fifo holds the sequencer
    assign push_if.valid = conv_done || (st_q == ST_HOLD);
    assign push_if.data = {sh_q, (st_q == ST_HOLD) ? res_q : SAR_RESULT};

    acst_fifo #(.W(DW), .DEPTH(DEPTH)) u_fifo (
        .clk(CLK_SYS),
        .rst(RST),
        .ce(CE),
        .wr(push_if),
        .rd(pop_if)
    );
    assign pop_if.ready = RESULT_READY;
    assign RESULT_VALID = pop_if.valid;
    assign RESULT_DATA = pop_if.data;

    // acquisition mask: in sequential auto-sample groups of two or four, next channel acquires while this one converts
    always_comb
    begin
        SH_ACQUIRE = 4'h0;
        if (st_q == ST_SAMPLE)
            SH_ACQUIRE = SIMULTANEOUS_SAMPLE ? sh_en : (4'h1 << sh_q);
        else if (st_q == ST_CONV && AUTO_SAMPLE_ENABLE &&
                 !SIMULTANEOUS_SAMPLE && nsh != 2'h0)
            SH_ACQUIRE = 4'h1 << (last_sh ? SH_RESET : sh_q + 1'b1);
    end
    assign SAMPLING = (st_q == ST_SAMPLE);
    assign CONVERTING = (st_q == ST_CONV);
    assign SH_CONVERT = sh_q;

    // helper counters seen only by the checks below
    logic [4:0] chk_conv_q, chk_sample_hold_bit_q;
    logic [DIV_W-1:0] gap_q;
    logic gap_ok_q;
    logic [5:0] chk_sample_hold_bit_now;
    // sampling ticks so far, counting a tick in the current cycle
    assign chk_sample_hold_bit_now = {1'b0, chk_sample_hold_bit_q} + 6'(tad_tick);
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            chk_conv_q <= '0;
            chk_sample_hold_bit_q <= '0;
            gap_q <= '0;
            gap_ok_q <= 1'b0;
        end
        else if (CE)
        begin
            if (st_q != ST_CONV || conv_done)
                chk_conv_q <= '0;
            else if (tad_tick)
                chk_conv_q <= chk_conv_q + 1'b1;
            if (st_q != ST_SAMPLE)
                chk_sample_hold_bit_q <= '0;
            else if (tad_tick && chk_sample_hold_bit_q != CNT_MAX)
                chk_sample_hold_bit_q <= chk_sample_hold_bit_q + 1'b1;
            gap_q <= div_tick ? '0 : gap_q + 1'b1;
            gap_ok_q <= MODULE_ON && !RC_CLOCK_SELECT && !div_hold &&
                        $stable(CONV_CLOCK_DIVIDER) && (gap_ok_q || div_tick);
        end
    end

    property p_conv_len;
        @(posedge CLK_SYS) disable iff (RST)
        conv_done |-> (chk_conv_q == CONV_LAST);
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion did not take twelve periods");

    property p_div_gap;
        @(posedge CLK_SYS) disable iff (RST)
        CE && div_tick && gap_ok_q && $stable(CONV_CLOCK_DIVIDER)
            |-> (gap_q == CONV_CLOCK_DIVIDER);
    endproperty
    a_div_gap: assert property (p_div_gap)
        else $error("conversion clock period wrong");

    property p_rc_src;
        @(posedge CLK_SYS) disable iff (RST)
        RC_CLOCK_SELECT && tad_tick |->
            $past(RC_OSC_PIN, 2) && !$past(RC_OSC_PIN, 3);
    endproperty
    a_rc_src: assert property (p_rc_src)
        else $error("rc mode tick without rc edge");

    property p_min_sample_hold_bit;
        @(posedge CLK_SYS) disable iff (RST)
        enter_conv |-> (chk_sample_hold_bit_now >= {1'b0, MIN_SAMPLE_TADS});
    endproperty
    a_min_sample_hold_bit: assert property (p_min_sample_hold_bit)
        else $error("conversion started without sampling");

    property p_auto_samc;
        @(posedge CLK_SYS) disable iff (RST)
        enter_conv && TRIGGER_SOURCE == TRIG_AUTO && $stable(INPUT_SELECT)
            |-> (chk_sample_hold_bit_now >= {1'b0, sample_hold_bit_need});
    endproperty
    a_auto_samc: assert property (p_auto_samc)
        else $error("auto sample ended early");

    property p_chan_restart;
        @(posedge CLK_SYS) disable iff (RST)
        CE && st_q == ST_SAMPLE && INPUT_SELECT != chan_q
            |=> st_q != ST_CONV;
    endproperty
    a_chan_restart: assert property (p_chan_restart)
        else $error("channel change did not restart sampling");

    property p_off;
        @(posedge CLK_SYS) disable iff (RST)
        CE && !MODULE_ON |=> !SAMPLING && !CONVERTING && !push_if.valid;
    endproperty
    a_off: assert property (p_off)
        else $error("sequencer active while module off");

    property p_auto_next;
        @(posedge CLK_SYS) disable iff (RST)
        CE && MODULE_ON && conv_done && push_if.ready &&
        AUTO_SAMPLE_ENABLE && !(SIMULTANEOUS_SAMPLE && !last_sh)
            |=> SAMPLING;
    endproperty
    a_auto_next: assert property (p_auto_next)
        else $error("sampling did not restart after conversion");

    property p_stall;
        @(posedge CLK_SYS) disable iff (RST)
        CE && MODULE_ON && st_q == ST_HOLD && !push_if.ready
            |=> st_q == ST_HOLD && push_if.valid;
    endproperty
    a_stall: assert property (p_stall)
        else $error("result dropped under back-pressure");
endmodule

/* File: testbench/acst_tb.sv */
// Purpose: self-checking bench for the conversion timing block
// Assumes: CLK_SYS at 100 MHz; inputs other than RC_OSC_PIN move 1 ns after each rising edge
// Notes: table rows cover auto timing; odd cases are hand-written after
`timescale 1ns/1ps
module testbench;
    import acst_pkg::*;
    typedef struct {
        logic [DIV_W-1:0] div;
        logic [SAMC_W-1:0] samc;
        logic [RES_W-1:0] sar;
        int exp_sample_hold_bit;
        int exp_conv;
    } acst_row_t;
    localparam int TMAX = 20000;
    localparam int NROWS = 5;
    // divider, sample clocks, result, then sample and convert lengths
    acst_row_t rows [NROWS] = '{
        '{6'h00, 5'h02, 10'h2A5, 2, 12},
        '{6'h00, 5'h00, 10'h155, 1, 12},
        '{6'h01, 5'h02, 10'h3FF, 4, 24},
        '{6'h09, 5'h01, 10'h000, 10, 120},
        '{6'h3F, 5'h03, 10'h1C3, 192, 768}
    };
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic CE = 1'b1;
    logic MODULE_ON = 1'b0;
    logic RC_CLOCK_SELECT = 1'b0;
    logic RC_OSC_PIN = 1'b0;
    logic [DIV_W-1:0] CONV_CLOCK_DIVIDER = 6'h00;
    logic [2:0] TRIGGER_SOURCE = 3'h0;
    logic AUTO_SAMPLE_ENABLE = 1'b0;
    logic SAMPLE_HOLD_BIT = 1'b0;
    logic SIMULTANEOUS_SAMPLE = 1'b0;
    logic [1:0] SH_CHANNEL_COUNT = 2'h0;
    logic [SAMC_W-1:0] AUTO_SAMPLE_CLOCKS = 5'h01;
    logic [3:0] INPUT_SELECT = 4'h0;
    logic EXT_TRIGGER = 1'b0;
    logic [RES_W-1:0] SAR_RESULT = 10'h000;
    logic RESULT_READY = 1'b1;
    logic SAMPLING;
    logic CONVERTING;
    logic [3:0] SH_ACQUIRE;
    logic [SH_W-1:0] SH_CONVERT;
    logic RESULT_VALID;
    logic [SH_W+RES_W-1:0] RESULT_DATA;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;

    acst_top #(.DEPTH(FIFO_DEPTH)) i_dut (
        .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .MODULE_ON(MODULE_ON),
        .RC_CLOCK_SELECT(RC_CLOCK_SELECT), .RC_OSC_PIN(RC_OSC_PIN),
        .CONV_CLOCK_DIVIDER(CONV_CLOCK_DIVIDER),
        .TRIGGER_SOURCE(TRIGGER_SOURCE),
        .AUTO_SAMPLE_ENABLE(AUTO_SAMPLE_ENABLE),
        .SAMPLE_HOLD_BIT(SAMPLE_HOLD_BIT),
        .SIMULTANEOUS_SAMPLE(SIMULTANEOUS_SAMPLE),
        .SH_CHANNEL_COUNT(SH_CHANNEL_COUNT),
        .AUTO_SAMPLE_CLOCKS(AUTO_SAMPLE_CLOCKS),
        .INPUT_SELECT(INPUT_SELECT), .EXT_TRIGGER(EXT_TRIGGER),
        .SAR_RESULT(SAR_RESULT), .RESULT_READY(RESULT_READY),
        .SAMPLING(SAMPLING), .CONVERTING(CONVERTING),
        .SH_ACQUIRE(SH_ACQUIRE), .SH_CONVERT(SH_CONVERT),
        .RESULT_VALID(RESULT_VALID), .RESULT_DATA(RESULT_DATA)
    );

    // system clock, and an rc oscillator of 80 ns off the rising clock edges
    always #5 CLK_SYS = ~CLK_SYS;
    always #40 RC_OSC_PIN = ~RC_OSC_PIN;

    // hang guard: a stuck sequencer must still reach the verdict
    always @(posedge CLK_SYS)
    begin
        cyc++;
        if (cyc == TMAX)
        begin
            n_errors++;
            $display("[FAIL] run length expected below %0d seen %0d", TMAX, cyc);
            test_done();
        end
    end

    task automatic test_done();
        $display("errors %0d, comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // lengths are counted by the bench, so a range covers exact and minimum
    task automatic check_len(input string what, input int lo, input int hi,
        input int got);
        cmp_count++;
        if (got < lo || got > hi)
        begin
            n_errors++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // one cycle on; outputs are settled and inputs may change
    task automatic tick();
        @(posedge CLK_SYS);
        #1;
    endtask

    task automatic wait_for(input logic conv);
        int w;
        w = 0;
        while ((conv ? CONVERTING : SAMPLING) !== 1'b1 && w < 4000)
        begin
            w++;
            tick();
        end
        check_len("phase start wait", 0, 3999, w);
    endtask

    task automatic run_len(input logic conv, output int n);
        n = 0;
        while ((conv ? CONVERTING : SAMPLING) === 1'b1 && n < 4000)
        begin
            n++;
            tick();
        end
    endtask

    // fields change only while the module is off
    task automatic setup(input logic [DIV_W-1:0] div,
        input logic [SAMC_W-1:0] samc, input logic [2:0] trig,
        input logic [1:0] chps, input logic sim, input logic rc,
        input logic autos);
        MODULE_ON = 1'b0;
        tick();
        CONV_CLOCK_DIVIDER = div;
        AUTO_SAMPLE_CLOCKS = samc;
        TRIGGER_SOURCE = trig;
        SH_CHANNEL_COUNT = chps;
        SIMULTANEOUS_SAMPLE = sim;
        RC_CLOCK_SELECT = rc;
        AUTO_SAMPLE_ENABLE = autos;
        tick();
        MODULE_ON = 1'b1;
        repeat (2) tick();
    endtask

    initial
    begin
        int n;
        int k;
        int nch;
        logic [3:0] acq;
        repeat (10) tick();
        check("idle in reset", 16'h0000,
            16'({SAMPLING, CONVERTING, RESULT_VALID}));
        RST = 1'b0;
        tick();
        // auto timing table: convert, resample, sample, result word
        for (int i = 0; i < NROWS; i++)
        begin
            SAR_RESULT = rows[i].sar;
            setup(rows[i].div, rows[i].samc, TRIG_AUTO, CHPS_ONE, 1'b0,
                1'b0, 1'b1);
            wait_for(1'b1);
            run_len(1'b1, n);
            check_len("conv", rows[i].exp_conv, rows[i].exp_conv, n);
            check("resample", 16'h0001, 16'(SAMPLING));
            run_len(1'b0, n);
            check_len("sample", rows[i].exp_sample_hold_bit, rows[i].exp_sample_hold_bit, n);
            k = 0;
            while (RESULT_VALID !== 1'b1 && k < 2000)
            begin
                k++;
                tick();
            end
            check("word", {6'h00, rows[i].sar}, {4'h0, RESULT_DATA});
        end
        // software sampling: a one-cycle bit still samples a full period
        setup(6'h03, 5'h00, TRIG_SW, CHPS_ONE, 1'b0, 1'b0, 1'b0);
        SAMPLE_HOLD_BIT = 1'b1;
        tick();
        SAMPLE_HOLD_BIT = 1'b0;
        wait_for(1'b0);
        run_len(1'b0, n);
        check_len("manual sample", 4, 4000, n);
        run_len(1'b1, n);
        check_len("manual conv", 45, 48, n);
        check("idle after manual", 16'h0000, 16'({SAMPLING, CONVERTING}));
        // outside trigger together with a channel change
        setup(6'h03, 5'h00, 3'h3, CHPS_ONE, 1'b0, 1'b0, 1'b1);
        wait_for(1'b0);
        repeat (12) tick();
        check("waits for trigger", 16'h0001, 16'(SAMPLING));
        INPUT_SELECT = 4'h5;
        EXT_TRIGGER = 1'b1;
        tick();
        EXT_TRIGGER = 1'b0;
        run_len(1'b0, n);
        check_len("resample on change", 3, 4000, n);
        run_len(1'b1, n);
        check_len("triggered conv", 48, 48, n);
        // clock enable freeze, then abort in mid conversion
        setup(6'h00, 5'h01, TRIG_AUTO, CHPS_ONE, 1'b0, 1'b0, 1'b1);
        wait_for(1'b1);
        CE = 1'b0;
        repeat (10) tick();
        check("frozen conv", 16'h0001, 16'(CONVERTING));
        CE = 1'b1;
        run_len(1'b1, n);
        check_len("conv after freeze", 12, 12, n);
        wait_for(1'b1);
        repeat (5) tick();
        MODULE_ON = 1'b0;
        tick();
        check("abort", 16'h0000,
            16'({SAMPLING, CONVERTING, SH_CONVERT}));
        k = 0;
        repeat (30)
        begin
            tick();
            if (RESULT_VALID === 1'b1 || SAMPLING === 1'b1)
                k++;
        end
        check_len("quiet when off", 0, 0, k);
        // sequential two and four channels: convert one, acquire next
        for (int c = 1; c <= 2; c++)
        begin
            nch = 2 << (c - 1);
            setup(6'h00, 5'h02, TRIG_AUTO, 2'(c), 1'b0, 1'b0, 1'b1);
            for (k = 0; k < 2 * nch; k++)
            begin
                wait_for(1'b1);
                acq = 4'h1 << ((k + 1) % nch);
                check("convert index", 16'(k % nch), 16'(SH_CONVERT));
                check("acquire next", 16'(acq), 16'(SH_ACQUIRE));
                run_len(1'b1, n);
                check("sample between", 16'h0001, 16'(SAMPLING));
            end
        end
        // simultaneous group converts its two channels back to back
        setup(6'h00, 5'h02, TRIG_AUTO, CHPS_TWO, 1'b1, 1'b0, 1'b1);
        wait_for(1'b1);
        run_len(1'b1, n);
        check_len("group conv", 24, 24, n);
        // rc clock: 8 system cycles a conversion period
        setup(6'h00, 5'h01, TRIG_AUTO, CHPS_ONE, 1'b0, 1'b1, 1'b1);
        wait_for(1'b1);
        run_len(1'b1, n);
        check_len("rc conv", 96, 96, n);
        // fill the fifo with the sink stalled, then drain it
        RESULT_READY = 1'b0;
        setup(6'h00, 5'h01, TRIG_AUTO, CHPS_ONE, 1'b0, 1'b0, 1'b1);
        repeat (300) tick();
        check("stall when full", 16'h0001,
            16'({SAMPLING, CONVERTING, RESULT_VALID}));
        MODULE_ON = 1'b0;
        RESULT_READY = 1'b1;
        k = 0;
        repeat (40)
        begin
            if (RESULT_VALID === 1'b1)
                k++;
            tick();
        end
        check_len("words drained", FIFO_DEPTH + 1, FIFO_DEPTH + 1, k);
        test_done();
    end
endmodule
